// file: rtl/psag_pkg.sv
/*
 Shared constants for the program space address generator.
 Assumes a 24-bit program word space and a 16-bit data space.
*/
package psag_pkg;
    localparam int PSAG_PADDR_W   = 24;
    localparam int PSAG_PWORD_W   = 24;
    localparam int PSAG_DWORD_W   = 16;
    localparam int PSAG_PAGE_W    = 8;
    localparam int PSAG_PAGE_MSB  = 7;
    localparam int PSAG_EA_W      = 16;
    localparam int PSAG_PC_HI     = 22;
    localparam int PSAG_PC_LO     = 1;
    localparam logic [7:0] PSAG_PAGE_RST = 8'h00;
    localparam logic [23:0] PSAG_ADDR_RST = 24'h000000;
    // Window base in data space: top half of the 16-bit data space
    localparam logic [15:0] PSAG_WIN_BASE = 16'h8000;
    localparam int PSAG_WIN_BIT   = 15;

    typedef enum logic [3:0] {
        PSAG_IDLE  = 4'b0001,
        PSAG_FETCH = 4'b0010,
        PSAG_TABLE = 4'b0100,
        PSAG_WIN   = 4'b1000
    } psag_src_type;
endpackage

// file: rtl/psag_lane.sv
/*
 Byte lane selector for table reads of a 24-bit program word.
 Assumes the caller registers the result.
*/
`timescale 1ns/1ps
module psag_lane
#(
    parameter int WORD_W = 24
)
(
    // Word and selection
    input  wire logic [WORD_W-1:0] word_in,
    input  wire logic              upper_in,
    input  wire logic              byte_in,
    input  wire logic              hi_byte_in,
    // Result
    output logic [15:0]            data_out
);
    logic [15:0] lo_word;
    logic [7:0]  up_byte;
    logic [7:0]  sel_byte;

    assign lo_word  = word_in[15:0];
    assign up_byte  = word_in[WORD_W-1:16];
    assign sel_byte = upper_in ? up_byte
                    : (hi_byte_in ? lo_word[15:8] : lo_word[7:0]);

    always_comb
    begin
        if (byte_in)
            data_out = {8'h00, sel_byte};
        else if (upper_in)
            data_out = {8'h00, up_byte};
        else
            data_out = lo_word;
    end
endmodule

// file: rtl/psag_top.sv
/*
 Program space address generator: forms program memory addresses for
 fetches, table reads/writes and the read-only data space window.
 Assumes the core holds a request for one cycle and that program
 memory returns read data combinationally in the same cycle.
*/
`timescale 1ns/1ps
import psag_pkg::*;
// Operation
// [R01] Program words are 24 bits wide and data words 16 bits wide.
// [R02] Table operations reach any byte or word of any program word.
// [R03] A data space window reads program memory and never writes it.
// [R04] The window returns only the low 16 bits of a program word.
// [R05] Fetch address is {0, pc[22:1], 0}.
// [R06] Table address is {table page, data effective address}.
// [R07] Table page MSB clear selects user space, set selects config.
module psag_top
(
    // Clock and reset
    input  wire logic                        sys_clk_in,
    input  wire logic                        rst_n_in,
    // Fetch request
    input  wire logic                        fetch_req_in,
    input  wire logic [psag_pkg::PSAG_PADDR_W-1:0] pc_in,
    // Table page load
    input  wire logic                        page_we_in,
    input  wire logic [psag_pkg::PSAG_PAGE_W-1:0]  page_wdata_in,
    // Table access
    input  wire logic                        table_read_op_in,
    input  wire logic                        table_write_op_in,
    input  wire logic                        tbl_upper_in,
    input  wire logic                        tbl_byte_in,
    input  wire logic [psag_pkg::PSAG_EA_W-1:0]    ea_in,
    input  wire logic [psag_pkg::PSAG_DWORD_W-1:0] tbl_wdata_in,
    // Data space window access
    input  wire logic                        win_rd_in,
    input  wire logic                        win_wr_in,
    input  wire logic [psag_pkg::PSAG_PAGE_W-1:0]  win_page_in,
    // Program memory side
    input  wire logic [psag_pkg::PSAG_PWORD_W-1:0] pmem_rdata_in,
    output logic [psag_pkg::PSAG_PADDR_W-1:0]      pmem_addr_out,
    output logic                             pmem_rd_out,
    output logic                             pmem_wr_out,
    output logic [psag_pkg::PSAG_PWORD_W-1:0]      pmem_wdata_out,
    output logic [2:0]                       pmem_lane_out,
    output logic                             pmem_cfg_out,
    // Core side results
    output logic [psag_pkg::PSAG_PAGE_W-1:0]       table_page_select_out,
    output logic [psag_pkg::PSAG_PWORD_W-1:0]      fetch_data_out,
    output logic [psag_pkg::PSAG_DWORD_W-1:0]      rdata_out,
    output logic                             rvalid_out,
    output logic                             fetch_valid_out
);
    import psag_pkg::*;

    logic [PSAG_PAGE_W-1:0]  table_page_select;
    logic [PSAG_PADDR_W-1:0] next_addr;
    logic                    next_rd;
    logic                    next_wr;
    logic [2:0]              next_lane;
    psag_src_type            next_src;
    psag_src_type            src;
    logic                    tbl_upper_q;
    logic                    tbl_byte_q;
    logic                    hi_byte_q;
    logic [15:0]             lane_data;

    assign table_page_select_out = table_page_select;

    // Page register
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            table_page_select <= PSAG_PAGE_RST;
        else if (page_we_in)
            table_page_select <= page_wdata_in;
    end

    // Source priority: fetch, then table, then window
    always_comb
    begin
        next_addr = PSAG_ADDR_RST;
        next_rd   = 1'b0;
        next_wr   = 1'b0;
        next_lane = 3'b000;
        next_src  = PSAG_IDLE;
        if (fetch_req_in)
        begin
            next_addr = {1'b0, pc_in[PSAG_PC_HI:PSAG_PC_LO], 1'b0}; // R05
            next_rd   = 1'b1;
            next_lane = 3'b111;
            next_src  = PSAG_FETCH;
        end
        else if (table_read_op_in || table_write_op_in)
        begin
            next_addr = {table_page_select, ea_in}; // R06
            next_rd   = table_read_op_in;
            next_wr   = table_write_op_in && !table_read_op_in;
            // Byte lanes of the 24-bit word R02
            if (tbl_upper_in)
                next_lane = 3'b100;
            else if (tbl_byte_in)
                next_lane = ea_in[0] ? 3'b010 : 3'b001;
            else
                next_lane = 3'b011;
            next_src  = PSAG_TABLE;
        end
        else if (win_rd_in)
        begin
            // Window maps the low 15 EA bits under a page R03
            next_addr = {win_page_in, 1'b0,
                         ea_in[PSAG_WIN_BIT-1:0]};
            next_rd   = 1'b1;
            next_lane = 3'b011; // R04
            next_src  = PSAG_WIN;
        end
        // Window writes fall through: nothing reaches memory R03
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pmem_addr_out  <= PSAG_ADDR_RST;
            pmem_rd_out    <= 1'b0;
            pmem_wr_out    <= 1'b0;
            pmem_lane_out  <= 3'b000;
            pmem_cfg_out   <= 1'b0;
            pmem_wdata_out <= '0;
            src            <= PSAG_IDLE;
            tbl_upper_q    <= 1'b0;
            tbl_byte_q     <= 1'b0;
            hi_byte_q      <= 1'b0;
        end
        else
        begin
            pmem_addr_out  <= next_addr;
            pmem_rd_out    <= next_rd;
            pmem_wr_out    <= next_wr;
            pmem_lane_out  <= next_lane;
            // Config space only for table accesses R07
            pmem_cfg_out   <= (next_src == PSAG_TABLE) &&
                              table_page_select[PSAG_PAGE_MSB];
            // Upper byte write uses low byte of the data word R02
            pmem_wdata_out <= tbl_upper_in
                            ? {tbl_wdata_in[7:0], 16'h0000}
                            : {8'h00, tbl_wdata_in};
            src            <= next_src;
            tbl_upper_q    <= tbl_upper_in;
            tbl_byte_q     <= tbl_byte_in;
            hi_byte_q      <= ea_in[0];
        end
    end

    psag_lane #(.WORD_W(PSAG_PWORD_W)) u_lane
    (
        .word_in    (pmem_rdata_in),
        .upper_in   (tbl_upper_q && src == PSAG_TABLE),
        .byte_in    (tbl_byte_q && src == PSAG_TABLE),
        .hi_byte_in (hi_byte_q),
        .data_out   (lane_data)
    );

    // Results register one cycle after the memory cycle
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata_out       <= '0;
            rvalid_out      <= 1'b0;
            fetch_data_out  <= '0;
            fetch_valid_out <= 1'b0;
        end
        else
        begin
            rvalid_out      <= pmem_rd_out && src != PSAG_FETCH;
            fetch_valid_out <= pmem_rd_out && src == PSAG_FETCH;
            if (pmem_rd_out && src == PSAG_FETCH)
                fetch_data_out <= pmem_rdata_in; // R01
            if (pmem_rd_out && src != PSAG_FETCH)
                rdata_out <= lane_data; // R04
        end
    end

    property p_fetch_addr;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        fetch_req_in |=> pmem_addr_out ==
            {1'b0, $past(pc_in[22:1]), 1'b0} && pmem_rd_out;
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) // R05
        else $error("fetch address malformed");

    property p_tbl_addr;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !fetch_req_in && table_read_op_in |=>
            pmem_addr_out == {$past(table_page_select), $past(ea_in)};
    endproperty
    a_tbl_addr: assert property (p_tbl_addr) // R06
        else $error("table address malformed");

    // A lone window write must leave program memory untouched
    property p_win_nowr;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        win_wr_in && !fetch_req_in && !table_read_op_in
            && !table_write_op_in |=> !pmem_wr_out;
    endproperty
    a_win_nowr: assert property (p_win_nowr) // R03
        else $error("window caused a write");

    property p_win_low;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        pmem_rd_out && src == PSAG_WIN |=>
            rvalid_out && rdata_out == $past(pmem_rdata_in[15:0]);
    endproperty
    a_win_low: assert property (p_win_low) // R04
        else $error("window returned wrong word");

    property p_cfg;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !fetch_req_in && (table_read_op_in || table_write_op_in)
            |=> pmem_cfg_out == $past(table_page_select[7]);
    endproperty
    a_cfg: assert property (p_cfg) // R07
        else $error("config space select wrong");

    property p_fetch_data;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        fetch_req_in |=> ##1 fetch_valid_out &&
            fetch_data_out == $past(pmem_rdata_in);
    endproperty
    a_fetch_data: assert property (p_fetch_data) // R01
        else $error("fetch word lost");

    property p_upper;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        pmem_rd_out && src == PSAG_TABLE && tbl_upper_q |=>
            rdata_out == {8'h00, $past(pmem_rdata_in[23:16])};
    endproperty
    a_upper: assert property (p_upper) // R02
        else $error("upper byte read wrong");

    property p_upwr;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        !fetch_req_in && table_write_op_in && !table_read_op_in
            && tbl_upper_in |=> pmem_wr_out && pmem_lane_out == 3'b100;
    endproperty
    a_upwr: assert property (p_upwr) // R02
        else $error("upper byte write lane wrong");

    c_fetch: cover property (@(posedge sys_clk_in) fetch_valid_out);
    c_tbl_wr: cover property (@(posedge sys_clk_in) pmem_wr_out);
    c_cfg: cover property (@(posedge sys_clk_in) pmem_cfg_out);
    c_win: cover property (@(posedge sys_clk_in)
        pmem_rd_out && src == PSAG_WIN);
endmodule

// file: verif/psag_pmem_model.sv
/*
 Behavioural program memory that answers reads in the address cycle.
 Assumes the address and read strobe come straight from the generator.
*/
`timescale 1ns/1ps
module psag_pmem_model
(
    // Request
    input  wire logic [23:0] addr_in,
    input  wire logic        rd_in,
    // Read data
    output logic [23:0]      rdata_out
);
    logic [23:0] pat;

    // Every 24-bit word holds a value derived from its own address
    assign pat = {addr_in[7:0] ^ 8'ha5, addr_in[23:8] ^ 16'h3c96};
    // Outside a read the bus shows garbage, never the last good word
    assign rdata_out = rd_in ? pat : ~pat;
endmodule

// file: verif/psag_top_tb.sv
/*
 Self-checking bench for the program space address generator.
 Assumes a memory model that returns read data in the address cycle.
*/
`timescale 1ns/1ps
module psag_top_tb;
    import psag_pkg::*;
    typedef logic [29:0] psag_acc_type;
    logic         sys_clk_in        = 1'b0;
    logic         rst_n_in          = 1'b0;
    logic         fetch_req_in      = 1'b0;
    logic         page_we_in        = 1'b0;
    logic         table_read_op_in  = 1'b0;
    logic         table_write_op_in = 1'b0;
    logic         tbl_upper_in      = 1'b0;
    logic         tbl_byte_in       = 1'b0;
    logic         win_rd_in         = 1'b0;
    logic         win_wr_in         = 1'b0;
    logic [23:0]  pc_in             = 24'h000000;
    logic [7:0]   page_wdata_in     = 8'h00;
    logic [7:0]   win_page_in       = 8'h00;
    logic [15:0]  ea_in             = 16'h0000;
    logic [15:0]  tbl_wdata_in      = 16'h0000;
    logic [23:0]  pmem_rdata_in, pmem_addr_out, pmem_wdata_out;
    logic [23:0]  fetch_data_out;
    logic [2:0]   pmem_lane_out;
    logic [7:0]   table_page_select_out;
    logic [15:0]  rdata_out;
    logic         pmem_rd_out, pmem_wr_out, pmem_cfg_out;
    logic         rvalid_out, fetch_valid_out;
    psag_acc_type aq[$];
    logic [15:0]  dq[$];
    logic [23:0]  fq[$];
    logic [24:0]  wq[$];
    logic [24:0]  w;
    logic [7:0]   page = 8'h00;
    integer       seed = 23913;
    int           num_errors = 0;
    int           tests_run = 0;
    int           cyc = 0;

    psag_top i_dut (.sys_clk_in, .rst_n_in, .fetch_req_in, .pc_in,
        .page_we_in, .page_wdata_in, .table_read_op_in, .table_write_op_in,
        .tbl_upper_in, .tbl_byte_in, .ea_in, .tbl_wdata_in, .win_rd_in,
        .win_wr_in, .win_page_in, .pmem_rdata_in, .pmem_addr_out,
        .pmem_rd_out, .pmem_wr_out, .pmem_wdata_out, .pmem_lane_out,
        .pmem_cfg_out, .table_page_select_out, .fetch_data_out, .rdata_out,
        .rvalid_out, .fetch_valid_out);
    psag_pmem_model i_pmem (.addr_in(pmem_addr_out), .rd_in(pmem_rd_out),
        .rdata_out(pmem_rdata_in));

    always #10 sys_clk_in = ~sys_clk_in;

    function automatic logic [23:0] mexp(input logic [23:0] a);
        return {a[7:0] ^ 8'ha5, a[23:8] ^ 16'h3c96};
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic cmp_acc(input psag_acc_type e, input psag_acc_type s);
        tests_run++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] pmem access exp %h got %h", e, s);
        end
    endtask

    task automatic cmp_val(input string n, input logic [31:0] e,
                           input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask

    task automatic load(input logic [7:0] v);
        @(negedge sys_clk_in);
        {fetch_req_in, table_read_op_in, table_write_op_in} = 3'h0;
        {win_rd_in, win_wr_in} = 2'h0;
        page_we_in = 1'b1;
        page_wdata_in = v;
        page = v;
        @(negedge sys_clk_in);
        page_we_in = 1'b0;
        cmp_val("page", v, table_page_select_out);
    endtask

    // Drives one request cycle and notes what must come back
    task automatic op(input logic f, tr, tw, wr, ww, up, by);
        logic [23:0] a;
        logic [23:0] m;
        @(negedge sys_clk_in);
        {fetch_req_in, table_read_op_in, table_write_op_in} = {f, tr, tw};
        {win_rd_in, win_wr_in, tbl_upper_in, tbl_byte_in} = {wr, ww, up, by};
        page_we_in = 1'b0;
        pc_in = 24'($random(seed));
        ea_in = 16'($random(seed));
        tbl_wdata_in = 16'($random(seed));
        win_page_in = 8'($random(seed));
        if (f)
        begin
            a = {1'b0, pc_in[22:1], 1'b0};
            aq.push_back({a, 2'b10, 3'b111, 1'b0});
            fq.push_back(mexp(a));
        end
        else if (tr | tw)
        begin
            a = {page, ea_in};
            m = mexp(a);
            aq.push_back({a, tr, !tr, up ? 3'b100 : !by ? 3'b011 :
                ea_in[0] ? 3'b010 : 3'b001, page[7]});
            if (tr)
                dq.push_back(up ? m[23:16] : !by ? m[15:0] :
                    ea_in[0] ? m[15:8] : m[7:0]);
            else
                wq.push_back({up, up ? {tbl_wdata_in[7:0], 16'h0000}
                    : {8'h00, tbl_wdata_in}});
        end
        else if (wr)
        begin
            a = {win_page_in, 1'b0, ea_in[14:0]};
            aq.push_back({a, 2'b10, 3'b011, 1'b0});
            m = mexp(a);
            dq.push_back(m[15:0]);
        end
    endtask

    // A strobe or result with nothing noted compares against unknown
    always @(negedge sys_clk_in)
    begin
        if (pmem_rd_out === 1'b1 || pmem_wr_out === 1'b1)
            cmp_acc(aq.size() ? aq.pop_front() : 'x, {pmem_addr_out,
                pmem_rd_out, pmem_wr_out, pmem_lane_out,
                pmem_cfg_out});
        if (pmem_wr_out === 1'b1)
        begin
            w = wq.size() ? wq.pop_front() : 'x;
            cmp_val("wdata", w[24] ? w[23:16] : w[23:0], w[24] ?
                pmem_wdata_out[23:16] : pmem_wdata_out);
        end
        if (fetch_valid_out === 1'b1)
            cmp_val("fetch", fq.size() ? fq.pop_front() : 'x,
                fetch_data_out);
        if (rvalid_out === 1'b1)
            cmp_val("rdata", dq.size() ? dq.pop_front() : 'x,
                rdata_out);
    end

    always @(posedge sys_clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (20) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        cmp_val("reset addr", 0, pmem_addr_out);
        cmp_val("reset page", 0, table_page_select_out);
        for (int i = 0; i < 12; i++)
        begin
            load({i[0], 7'($random(seed))});
            op(1, 0, 0, 0, 0, 0, 0);
            op(0, 1, 0, 0, 0, 0, 0);
            op(0, 1, 0, 0, 0, 0, 1);
            op(0, 1, 0, 0, 0, 1, 0);
            op(0, 0, 1, 0, 0, 0, 0);
            op(0, 0, 1, 0, 0, 1, 0);
            op(0, 0, 1, 0, 0, 0, 1);
            op(0, 0, 0, 1, 0, 0, 0);
            op(0, 0, 0, 0, 1, 0, 0);
            op(1, 1, 0, 1, 0, 0, 0);
            op(0, 1, 1, 0, 0, 0, 1);
            op(0, 0, 0, 1, 1, 0, 0);
        end
        op(0, 0, 0, 0, 0, 0, 0);
        repeat (3) @(negedge sys_clk_in);
        cmp_val("pending", 0, aq.size() + dq.size() + fq.size() + wq.size());
        report_and_stop();
    end
endmodule
